// ==== hdl/pcsr_pkg.sv ====
// Package: offsets, field layouts, reset values and carriers for the protection register bank
package pcsr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PCSR_OFF_OV_LEVEL = 8'h26;
    localparam logic [7:0] PCSR_OFF_UV_LEVEL = 8'h27;
    localparam logic [7:0] PCSR_OFF_OT_LEVEL = 8'h28;
    localparam logic [7:0] PCSR_OFF_PROT_DISABLE = 8'h29;
    localparam logic [7:0] PCSR_OFF_SYS_FAULT = 8'h2A;
    localparam logic [7:0] PCSR_OFF_PHASE_OC = 8'h2B;
    localparam logic [7:0] PCSR_OFF_EA_GAIN = 8'h2C;
    localparam logic [7:0] PCSR_OFF_SHED_SKIP = 8'h2D;
    localparam logic [7:0] PCSR_OFF_IMON_READ = 8'h2E;
    localparam logic [7:0] PCSR_OFF_OUTSENSE_READ = 8'h2F;
    localparam logic [7:0] PCSR_OFF_TSEN_READ = 8'h30;

    // ------------------------------------------------------------
    // Field widths and positions
    // ------------------------------------------------------------
    localparam int PCSR_SEL_W = 2;
    localparam int PCSR_SYS_W = 5;
    localparam int PCSR_PHASES = 8;
    localparam int PCSR_ADC_W = 8;
    localparam int PCSR_BIT_MON_OT = 4;
    localparam int PCSR_BIT_OT = 3;
    localparam int PCSR_BIT_SUM_OC = 2;
    localparam int PCSR_BIT_UV = 1;
    localparam int PCSR_BIT_OV = 0;
    localparam int PCSR_BIT_SHED = 1;
    localparam int PCSR_BIT_SKIP = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] PCSR_RST_OV_LEVEL = 2'h0;
    localparam logic [1:0] PCSR_RST_UV_LEVEL = 2'h0;
    localparam logic [1:0] PCSR_RST_OT_LEVEL = 2'h0;
    localparam logic [4:0] PCSR_RST_DISABLE = 5'h00;
    localparam logic [1:0] PCSR_RST_EA_GAIN = 2'h2;
    localparam logic PCSR_RST_SHED = 1'b0;
    localparam logic [7:0] PCSR_RST_ZERO = 8'h00;

    // Power-state input levels
    typedef enum logic [1:0] {
        PCSR_PS_LOW = 2'h0,
        PCSR_PS_MID = 2'h1,
        PCSR_PS_HIGH = 2'h2
    } pcsr_pstate_e;

    // Trip levels in percent / degrees C / gain units
    typedef struct packed {
        logic [7:0] ov_percent;
        logic [7:0] uv_percent;
        logic [7:0] ot_celsius;
        logic [3:0] ea_gain;
    } pcsr_levels_s;

    // Protection enables and phase-mode outputs
    typedef struct packed {
        logic mon_ot_en;
        logic ot_en;
        logic sum_oc_en;
        logic uv_en;
        logic ov_en;
        logic auto_phase_shedding;
        logic all_phases;
        logic pulse_skip_mode;
    } pcsr_ctrl_s;

    // ADC readings
    typedef struct packed {
        logic [7:0] current_monitor_voltage;
        logic [7:0] output_sense_voltage;
        logic [7:0] temperature_sense_voltage;
    } pcsr_adc_s;

endpackage

// ==== hdl/pcsr_sticky_bits.sv ====
// Sticky trip flags: set by hardware events, cleared only by reset
`timescale 1ns/100ps
`default_nettype none
module pcsr_sticky_bits #(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] event_i,
    output logic [WIDTH-1:0] flags_o
);

    // Flags latch once triggered; host writes never reach them
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            flags_o <= '0;
        end else begin
            flags_o <= flags_o | event_i;
        end
    end

endmodule // pcsr_sticky_bits
`default_nettype wire

// ==== hdl/pcsr_regs.sv ====
// Protection configuration and status register bank
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Over-voltage trip select: 00=150%,01=140%,10=130%,11=120%; reset 00.
// - Under-voltage trip select: 00=40%,01=30%,10=50%,11=60%; reset 00.
// - Over-temperature select: 00=150C,01=160C,10=170C,11=140C; reset 00.
// - Five disable bits, reset 0; writing 1 disables that protection.
// - Five read-only system fault flags, set when protection trips.
// - Eight read-only per-phase over-current flags, bit n-1 for phase n.
// - Error-amp gain select: 00=4,01=6,10=8,11=10; reset 10.
// - Mid power state: shedding when bit 0, all phases when bit 1.
// - Low power state: pulse skip when bit 0; reset is a product option.
// - Current-monitor reading, 8-bit read-only, 6.25mV per count, reset 0.
// - Output-sense reading, 8-bit read-only, 6.25mV per count, reset 0.
// - Temperature-sense reading, 8-bit read-only, 12.5mV per count, reset 0.
module pcsr_regs #(
    parameter logic SKIP_RESET = 1'b0
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [4:0] sys_trip_i,
    input wire logic [7:0] phase_trip_i,
    input wire logic adc_valid_i,
    input wire pcsr_pkg::pcsr_adc_s adc_i,
    input wire pcsr_pkg::pcsr_pstate_e power_state_input_i,
    output pcsr_pkg::pcsr_levels_s levels_o,
    output pcsr_pkg::pcsr_ctrl_s ctrl_o,
    output pcsr_pkg::pcsr_adc_s adc_o
);
    import pcsr_pkg::*;

    logic [1:0] ov_sel_reg;
    logic [1:0] uv_sel_reg;
    logic [1:0] ot_sel_reg;
    logic [4:0] disable_reg;
    logic [1:0] gain_reg;
    logic shed_reg;
    logic skip_reg;
    logic [4:0] sys_flags;
    logic [7:0] phase_flags;
    logic [4:0] sys_gated;
    pcsr_adc_s adc_reg;
    logic [7:0] rdata_next;
    logic [7:0] rdata_reg;

    // ------------------------------------------------------------
    // Writable configuration
    // ------------------------------------------------------------

    // Trip-level selects; only the low two bits are stored
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ov_sel_reg <= PCSR_RST_OV_LEVEL;
            uv_sel_reg <= PCSR_RST_UV_LEVEL;
            ot_sel_reg <= PCSR_RST_OT_LEVEL;
        end else if (reg_wr_i) begin
            if (reg_addr_i == PCSR_OFF_OV_LEVEL) begin
                ov_sel_reg <= reg_wdata_i[PCSR_SEL_W-1:0];
            end
            if (reg_addr_i == PCSR_OFF_UV_LEVEL) begin
                uv_sel_reg <= reg_wdata_i[PCSR_SEL_W-1:0];
            end
            if (reg_addr_i == PCSR_OFF_OT_LEVEL) begin
                ot_sel_reg <= reg_wdata_i[PCSR_SEL_W-1:0];
            end
        end
    end

    // Protection disables
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            disable_reg <= PCSR_RST_DISABLE;
        end else if (reg_wr_i && reg_addr_i == PCSR_OFF_PROT_DISABLE) begin
            disable_reg <= reg_wdata_i[PCSR_SYS_W-1:0];
        end
    end

    // Gain and phase-mode options; skip reset follows the ordered product option
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            gain_reg <= PCSR_RST_EA_GAIN;
            shed_reg <= PCSR_RST_SHED;
            skip_reg <= SKIP_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == PCSR_OFF_EA_GAIN) begin
                gain_reg <= reg_wdata_i[PCSR_SEL_W-1:0];
            end
            if (reg_addr_i == PCSR_OFF_SHED_SKIP) begin
                shed_reg <= reg_wdata_i[PCSR_BIT_SHED];
                skip_reg <= reg_wdata_i[PCSR_BIT_SKIP];
            end
        end
    end

    // ------------------------------------------------------------
    // Decoded levels
    // ------------------------------------------------------------

    // Code tables kept as plain cases so each code maps visibly to its level
    always_comb begin
        unique case (ov_sel_reg)
            2'h0: levels_o.ov_percent = 8'h96;
            2'h1: levels_o.ov_percent = 8'h8C;
            2'h2: levels_o.ov_percent = 8'h82;
            2'h3: levels_o.ov_percent = 8'h78;
        endcase
        unique case (uv_sel_reg)
            2'h0: levels_o.uv_percent = 8'h28;
            2'h1: levels_o.uv_percent = 8'h1E;
            2'h2: levels_o.uv_percent = 8'h32;
            2'h3: levels_o.uv_percent = 8'h3C;
        endcase
        unique case (ot_sel_reg)
            2'h0: levels_o.ot_celsius = 8'h96;
            2'h1: levels_o.ot_celsius = 8'hA0;
            2'h2: levels_o.ot_celsius = 8'hAA;
            2'h3: levels_o.ot_celsius = 8'h8C;
        endcase
        unique case (gain_reg)
            2'h0: levels_o.ea_gain = 4'h4;
            2'h1: levels_o.ea_gain = 4'h6;
            2'h2: levels_o.ea_gain = 4'h8;
            2'h3: levels_o.ea_gain = 4'hA;
        endcase
    end

    // ------------------------------------------------------------
    // Protection enables and phase mode
    // ------------------------------------------------------------

    // A disable bit of 1 switches that protection off
    assign ctrl_o.mon_ot_en = ~disable_reg[PCSR_BIT_MON_OT];
    assign ctrl_o.ot_en = ~disable_reg[PCSR_BIT_OT];
    assign ctrl_o.sum_oc_en = ~disable_reg[PCSR_BIT_SUM_OC];
    assign ctrl_o.uv_en = ~disable_reg[PCSR_BIT_UV];
    assign ctrl_o.ov_en = ~disable_reg[PCSR_BIT_OV];

    // Mid state: shed or run all; high state always runs all phases
    assign ctrl_o.auto_phase_shedding = (power_state_input_i == PCSR_PS_MID) && !shed_reg;
    assign ctrl_o.all_phases = (power_state_input_i == PCSR_PS_HIGH) ||
                               ((power_state_input_i == PCSR_PS_MID) && shed_reg);
    // Pulse skipping only in the low state
    assign ctrl_o.pulse_skip_mode = (power_state_input_i == PCSR_PS_LOW) && !skip_reg;

    // ------------------------------------------------------------
    // Fault flags
    // ------------------------------------------------------------

    // A disabled protection cannot raise its flag
    assign sys_gated = sys_trip_i & ~disable_reg;

    pcsr_sticky_bits #(
        .WIDTH(PCSR_SYS_W)
    ) u_sys_flags (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .event_i(sys_gated),
        .flags_o(sys_flags)
    );

    pcsr_sticky_bits #(
        .WIDTH(PCSR_PHASES)
    ) u_phase_flags (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .event_i(phase_trip_i),
        .flags_o(phase_flags)
    );

    // ------------------------------------------------------------
    // ADC results
    // ------------------------------------------------------------

    // Conversion results loaded from the converters only, never from the host
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            adc_reg <= '0;
        end else if (adc_valid_i) begin
            adc_reg <= adc_i;
        end
    end

    assign adc_o = adc_reg;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------

    // Read mux; unused upper bits and unmapped offsets read zero
    always_comb begin
        rdata_next = PCSR_RST_ZERO;
        unique case (reg_addr_i)
            PCSR_OFF_OV_LEVEL: rdata_next = {6'h00, ov_sel_reg};
            PCSR_OFF_UV_LEVEL: rdata_next = {6'h00, uv_sel_reg};
            PCSR_OFF_OT_LEVEL: rdata_next = {6'h00, ot_sel_reg};
            PCSR_OFF_PROT_DISABLE: rdata_next = {3'h0, disable_reg};
            PCSR_OFF_SYS_FAULT: rdata_next = {3'h0, sys_flags};
            PCSR_OFF_PHASE_OC: rdata_next = phase_flags;
            PCSR_OFF_EA_GAIN: rdata_next = {6'h00, gain_reg};
            PCSR_OFF_SHED_SKIP: rdata_next = {6'h00, shed_reg, skip_reg};
            PCSR_OFF_IMON_READ: rdata_next = adc_reg.current_monitor_voltage;
            PCSR_OFF_OUTSENSE_READ: rdata_next = adc_reg.output_sense_voltage;
            PCSR_OFF_TSEN_READ: rdata_next = adc_reg.temperature_sense_voltage;
            default: rdata_next = PCSR_RST_ZERO;
        endcase
    end

    // Registered read data, held until the next read strobe
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_reg <= PCSR_RST_ZERO;
        end else if (reg_rd_i) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

endmodule // pcsr_regs
`default_nettype wire

// ==== testbench/pcsr_host.sv ====
// Host model: write and read cycles on the register strobe port
`timescale 1ns/100ps
`default_nettype none
module pcsr_host (
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    output logic rd_o
);
    // Idle lines at time zero
    initial begin
        {addr_o, wr_o, wdata_o, rd_o} = 18'h0;
    end
    // One-cycle strobe; released lines show inverted values, not stale ones
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
        @(negedge clock_i);
        {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
    endtask
    // Read data is registered, so it is taken one edge after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_i);
        {addr_o, rd_o} = {a, 1'b1};
        @(negedge clock_i);
        {addr_o, rd_o} = {~a, 1'b0};
        d = rdata_i;
    endtask
endmodule // pcsr_host
`default_nettype wire

// ==== testbench/pcsr_regs_sva.sv ====
// Port checker for the protection register bank
`timescale 1ns/100ps
`default_nettype none
module pcsr_regs_sva (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic adc_valid_i,
    input wire pcsr_pkg::pcsr_adc_s adc_i,
    input wire pcsr_pkg::pcsr_pstate_e power_state_input_i,
    input wire pcsr_pkg::pcsr_levels_s levels_o,
    input wire pcsr_pkg::pcsr_ctrl_s ctrl_o,
    input wire pcsr_pkg::pcsr_adc_s adc_o
);
    import pcsr_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // A write strobe aimed at one offset
    sequence s_wr(logic [7:0] off);
        reg_wr_i && reg_addr_i == off;
    endsequence
    a_ov_level:
    assert property (s_wr(8'h26) |=> levels_o.ov_percent == 8'h96 - 8'h0A * $past(reg_wdata_i[1:0]))
        else $error("over-voltage level wrong");
    a_gain_sel:
    assert property (s_wr(8'h2C) |=> levels_o.ea_gain == 4'h4 + 4'h2 * $past(reg_wdata_i[1:0]))
        else $error("gain wrong");
    a_disable_bits:
    assert property (s_wr(8'h29) |=> ctrl_o[7:3] == ~$past(reg_wdata_i[4:0]))
        else $error("enables wrong");
    a_mid_shed:
    assert property (power_state_input_i == PCSR_PS_MID |-> ctrl_o[2] != ctrl_o[1])
        else $error("mid state mode wrong");
    a_low_skip:
    assert property (s_wr(8'h2D) ##1 power_state_input_i == PCSR_PS_LOW
        |-> ctrl_o.pulse_skip_mode == !$past(reg_wdata_i[0]))
        else $error("skip mode wrong");
    a_adc_load:
    assert property (adc_valid_i |=> adc_o == $past(adc_i))
        else $error("adc load wrong");
    a_ro_ignored:
    assert property (s_wr(8'h2E) ##0 !adc_valid_i |=> $stable(adc_o))
        else $error("read-only reading changed");
    a_reset_vals:
    assert property ($fell(srst_i) |-> levels_o[27:12] == 16'h9628 && levels_o[3:0] == 4'h8
        && reg_rdata_o == 8'h00)
        else $error("reset values wrong");
    a_rdata_hold:
    assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
endmodule // pcsr_regs_sva
bind pcsr_regs pcsr_regs_sva pcsr_regs_sva_i (.clock_i(clock_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .adc_valid_i(adc_valid_i),
    .adc_i(adc_i), .power_state_input_i(power_state_input_i), .levels_o(levels_o),
    .ctrl_o(ctrl_o), .adc_o(adc_o));
`default_nettype wire

// ==== testbench/pcsr_regs_test.sv ====
// Self-checking bench for the protection register bank
`timescale 1ns/100ps
`default_nettype none
module pcsr_regs_test;
    import pcsr_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd;
    logic adc_valid = 1'b0;
    logic [4:0] sys_trip = 5'h00;
    logic [7:0] phase_trip = 8'h00;
    pcsr_adc_s adc = 24'h0;
    pcsr_adc_s adc_q;
    pcsr_pstate_e pstate = PCSR_PS_HIGH;
    pcsr_levels_s levels;
    pcsr_ctrl_s ctrl;
    int miscompares = 0;
    int num_checks = 0;
    logic [7:0] ov_t [4] = '{8'h96, 8'h8C, 8'h82, 8'h78};
    logic [7:0] uv_t [4] = '{8'h28, 8'h1E, 8'h32, 8'h3C};
    logic [7:0] ot_t [4] = '{8'h96, 8'hA0, 8'hAA, 8'h8C};
    logic [3:0] ga_t [4] = '{4'h4, 4'h6, 4'h8, 4'hA};
    logic [7:0] rst_t [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    always #2.5 clock_i = ~clock_i;
    pcsr_regs #(.SKIP_RESET(1'b0)) pcsr_regs_i (.clock_i(clock_i), .srst_i(srst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .sys_trip_i(sys_trip), .phase_trip_i(phase_trip),
        .adc_valid_i(adc_valid), .adc_i(adc), .power_state_input_i(pstate),
        .levels_o(levels), .ctrl_o(ctrl), .adc_o(adc_q));
    pcsr_host pcsr_host_i (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
        .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
    // Compare and count; wide enough for the level struct
    task automatic chk(input logic [27:0] got, input logic [27:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        pcsr_host_i.rd_reg(a, v);
        chk(28'(v), 28'(e));
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog: the host cycles have fixed length, so this only catches a hang
    initial begin
        #200000;
        miscompares++;
        test_done;
    end
    initial begin
        repeat (2) @(negedge clock_i);
        srst_i = 1'b0;
        // Reset values, offset 0x31 included as unmapped
        for (int i = 0; i < 12; i++) rdchk(8'h26 + 8'(i), rst_t[i]);
        chk(28'(levels), 28'({8'h96, 8'h28, 8'h96, 4'h8}));
        chk(28'(ctrl[2:0]), 28'h2);
        // Every select code, with upper bits set; the 0x2C readback proves they read zero
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 3; r++) begin
                pcsr_host_i.wr_reg(8'h26 + 8'(r), 8'hFC | 8'(c));
            end
            pcsr_host_i.wr_reg(8'h2C, 8'hFC | 8'(c));
            chk(28'(levels), 28'({ov_t[c], uv_t[c], ot_t[c], ga_t[c]}));
            rdchk(8'h2C, 8'(c));
        end
        // Disabled protections stay silent; phase flags are never gated
        pcsr_host_i.wr_reg(8'h29, 8'h15);
        chk(28'(ctrl[7:3]), 28'h0A);
        @(negedge clock_i);
        {sys_trip, phase_trip} = {5'h1F, 8'h81};
        @(negedge clock_i);
        {sys_trip, phase_trip} = 13'h0;
        pcsr_host_i.wr_reg(8'h2A, 8'hFF);
        pcsr_host_i.wr_reg(8'h2B, 8'h00);
        rdchk(8'h2A, 8'h0A);
        rdchk(8'h2B, 8'h81);
        // Full-scale, one-count and mid-scale readings
        @(negedge clock_i);
        {adc, adc_valid} = {24'hFF0180, 1'b1};
        @(negedge clock_i);
        {adc, adc_valid} = 25'h0;
        chk(28'(adc_q), 28'hFF0180);
        pcsr_host_i.wr_reg(8'h2E, 8'h00);
        rdchk(8'h2E, 8'hFF);
        rdchk(8'h2F, 8'h01);
        rdchk(8'h30, 8'h80);
        // Skip bit checked in the low state, shed bit in the mid state
        for (int v = 0; v < 4; v++) begin
            pstate = PCSR_PS_LOW;
            pcsr_host_i.wr_reg(8'h2D, 8'(v));
            chk(28'(ctrl[0]), 28'(!v[0]));
            // Hold the low state one more edge so the skip assertion sees it
            @(negedge clock_i);
            pstate = PCSR_PS_MID;
            @(negedge clock_i);
            chk(28'(ctrl[2:1]), v[1] ? 28'h1 : 28'h2);
        end
        // Reset in mid-run clears flags and restores defaults
        srst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        srst_i = 1'b0;
        rdchk(8'h2A, 8'h00);
        rdchk(8'h2D, 8'h00);
        test_done;
    end
endmodule // pcsr_regs_test
`default_nettype wire
